/* core/dss_consts.svh */
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define DSS_OFS_STATUS   8'h04
`define DSS_OFS_CONTROL  8'h08
`define DSS_CTRL_RESET   8'h00

// ----------------------------------------------------------------
// control field layout, slot n sits at n * stride
// ----------------------------------------------------------------
`define DSS_SLOT_STRIDE  4
`define DSS_REG_BIT      0
`define DSS_VSEL_BIT     1
`define DSS_STATE_LSB    2

// ----------------------------------------------------------------
// status field layout, slot n at lsb + 2 * n
// ----------------------------------------------------------------
`define DSS_STATUS_LSB   4
`define DSS_STATUS_W     2

// ----------------------------------------------------------------
// serial interface
// ----------------------------------------------------------------
`define DSS_DEV_ADDR     7'h3c
`define DSS_BYTE_BITS    4'h8
`define DSS_LAST_TX_BIT  4'h7

`endif

/* core/dss_pkg.sv */
`default_nettype none

package dss_pkg;

	// stored interface state field values
	typedef enum logic [1:0] {
		DSS_STATE_DOWN     = 2'b00,
		DSS_STATE_ISOLATED = 2'b01,
		DSS_STATE_BANNED   = 2'b10,
		DSS_STATE_ACTIVE   = 2'b11
	} dss_slot_state_e;

	// derived status codes as read back
	typedef enum logic [1:0] {
		DSS_STS_DOWN     = 2'b00,
		DSS_STS_ISOLATED = 2'b01,
		DSS_STS_POWERED  = 2'b10,
		DSS_STS_ACTIVE   = 2'b11
	} dss_status_e;

	// serial slave sequencer
	typedef enum logic [2:0] {
		DSS_I2C_IDLE  = 3'b000,
		DSS_I2C_ADDR  = 3'b001,
		DSS_I2C_AACK  = 3'b010,
		DSS_I2C_WDATA = 3'b011,
		DSS_I2C_WACK  = 3'b100,
		DSS_I2C_RDATA = 3'b101,
		DSS_I2C_RACK  = 3'b110
	} dss_i2c_state_e;

endpackage : dss_pkg

`default_nettype wire

/* core/dss_slot_stage.sv */
`include "dss_consts.svh"
`default_nettype none

module dss_slot_stage #(
	parameter int SIG_W = 3
) (
	input  wire logic               ref_clk,
	input  wire logic               srst,
	input  wire logic [1:0]         stateField,
	input  wire logic               regOn,
	input  wire logic               voltSel,
	input  wire logic [SIG_W-1:0]   bbSig,
	output var  logic [1:0]         statusCode,
	output logic                    ldoOn,
	output logic                    ldoPullDn,
	output logic                    ldoHighV,
	output logic [SIG_W-1:0]        cardSig,
	output logic                    cardDrvEn,
	output logic                    cardPullDn
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (SIG_W < 1) begin : g_bad_width
		$error("dss_slot_stage: SIG_W must be at least one");
	end

	logic             ldoOn_q, ldoOn_d;
	logic             ldoPullDn_q, ldoPullDn_d;
	logic             ldoHighV_q, ldoHighV_d;
	logic [SIG_W-1:0] cardSig_q, cardSig_d;
	logic             cardDrvEn_q, cardDrvEn_d;
	logic             cardPullDn_q, cardPullDn_d;

	// ----------------------------------------------------------------
	// status decode, purely from this slot's own fields
	// ----------------------------------------------------------------
	// regulator bit only gates the status, never the stored state
	always_comb begin
		statusCode = dss_pkg::DSS_STS_DOWN;
		if (!regOn) begin
			statusCode = dss_pkg::DSS_STS_DOWN;
		end else begin
			case (stateField)
				dss_pkg::DSS_STATE_DOWN:     statusCode = dss_pkg::DSS_STS_POWERED;
				dss_pkg::DSS_STATE_ISOLATED: statusCode = dss_pkg::DSS_STS_ISOLATED;
				dss_pkg::DSS_STATE_BANNED:   statusCode = dss_pkg::DSS_STS_POWERED;
				dss_pkg::DSS_STATE_ACTIVE:   statusCode = dss_pkg::DSS_STS_ACTIVE;
				default:                     statusCode = dss_pkg::DSS_STS_DOWN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pin behaviour per status
	// ----------------------------------------------------------------
	// pins lag the status by one edge so every pin output is a flop; statusCode is not
	always_comb begin
		ldoOn_d      = regOn;
		ldoPullDn_d  = ~regOn;
		ldoHighV_d   = voltSel;
		cardSig_d    = '0;
		cardDrvEn_d  = 1'b0;
		cardPullDn_d = 1'b1;
		case (statusCode)
			dss_pkg::DSS_STS_DOWN: begin
				cardDrvEn_d  = 1'b0;
				cardPullDn_d = 1'b1;
			end
			dss_pkg::DSS_STS_POWERED: begin
				// totem pole stage drives low instead of the resistor
				cardSig_d    = '0;
				cardDrvEn_d  = 1'b1;
				cardPullDn_d = 1'b0;
			end
			dss_pkg::DSS_STS_ISOLATED: begin
				cardSig_d    = cardSig_q;
				cardDrvEn_d  = 1'b1;
				cardPullDn_d = 1'b0;
			end
			dss_pkg::DSS_STS_ACTIVE: begin
				cardSig_d    = bbSig;
				cardDrvEn_d  = 1'b1;
				cardPullDn_d = 1'b0;
			end
			default: begin
				cardDrvEn_d  = 1'b0;
				cardPullDn_d = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// pin registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ldoOn_q      <= 1'b0;
			ldoPullDn_q  <= 1'b1;
			ldoHighV_q   <= 1'b0;
			cardSig_q    <= '0;
			cardDrvEn_q  <= 1'b0;
			cardPullDn_q <= 1'b1;
		end else begin
			ldoOn_q      <= ldoOn_d;
			ldoPullDn_q  <= ldoPullDn_d;
			ldoHighV_q   <= ldoHighV_d;
			cardSig_q    <= cardSig_d;
			cardDrvEn_q  <= cardDrvEn_d;
			cardPullDn_q <= cardPullDn_d;
		end
	end

	assign ldoOn      = ldoOn_q;
	assign ldoPullDn  = ldoPullDn_q;
	assign ldoHighV   = ldoHighV_q;
	assign cardSig    = cardSig_q;
	assign cardDrvEn  = cardDrvEn_q;
	assign cardPullDn = cardPullDn_q;

endmodule : dss_slot_stage

`default_nettype wire

/* core/dss_slot_ctrl_regs.sv */
// What this block does
// - slot one state field at control bits 3:2, slot two at 7:6, control at 08h.
// - status bits 5:4 give slot one code, 7:6 slot two, status at 04h.
// - regulator bit 0 and 4; zero is off with pull-down, one is on.
// - voltage select bit 1 and 5; zero picks 1.8 V, one picks 2.95 V.
// - regulator bit zero always reports status 00 for that slot.
// - state 00 with regulator on reports status 10.
// - state 01 with regulator on reports 01, isolated only while powered.
// - state 11 with regulator on reports 11, active only while powered.
// - isolated state holds each card output at its last level, driven.
// - active outputs follow inputs; powered down enables the pull-down resistor.
// - state 10 is stored as written; reports 00 or 10 by regulator bit.
// - no state value, including 10, changes any regulator bit.
// - regulator bits never change stored state bits, only derived status.
// - reset clears the control register to zero, both slots powered down.
// - status register is read only, built from state and regulator bits.
`include "dss_consts.svh"
`default_nettype none

module dss_slot_ctrl_regs #(
	parameter logic [6:0] DEV_ADDR = `DSS_DEV_ADDR,
	parameter int         SIG_W    = 3
) (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 sclIn,
	input  wire logic                 sdaIn,
	output logic                      sdaOut,
	output logic                      sdaOe,
	input  wire logic [2*SIG_W-1:0]   bbSig,
	output logic [1:0]                ldoOn,
	output logic [1:0]                ldoPullDn,
	output logic [1:0]                ldoHighV,
	output logic [2*SIG_W-1:0]        cardSig,
	output logic [1:0]                cardDrvEn,
	output logic [1:0]                cardPullDn
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (SIG_W < 1) begin : g_bad_width
		$error("dss_slot_ctrl_regs: SIG_W must be at least one");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dss_pkg::dss_i2c_state_e state_q, state_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] ptr_q, ptr_d;
	logic [7:0] rxShift_q, rxShift_d;
	logic [7:0] txShift_q, txShift_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic       readMode_q, readMode_d;
	logic       firstByte_q, firstByte_d;
	logic       nack_q, nack_d;
	logic       sdaOe_q, sdaOe_d;
	logic       sdaOut_q;
	logic       scl_q, scl_d;
	logic       sda_q, sda_d;

	logic       sclRise, sclFall, startSeen, stopSeen;
	logic [7:0] statusByte;
	logic [7:0] readByte;
	logic [7:0] rxNext;
	logic [3:0] statusCodes;
	logic       ctrlWe;

	// ----------------------------------------------------------------
	// per slot status and pin stage
	// ----------------------------------------------------------------
	for (genvar s = 0; s < 2; s++) begin : g_slot
		localparam int BASE = s * `DSS_SLOT_STRIDE;
		dss_slot_stage #(
			.SIG_W (SIG_W)
		) u_stage (
			.ref_clk    (ref_clk),
			.srst       (srst),
			.stateField (ctrl_q[BASE+`DSS_STATE_LSB +: 2]),
			.regOn      (ctrl_q[BASE+`DSS_REG_BIT]),
			.voltSel    (ctrl_q[BASE+`DSS_VSEL_BIT]),
			.bbSig      (bbSig[s*SIG_W +: SIG_W]),
			.statusCode (statusCodes[s*2 +: 2]),
			.ldoOn      (ldoOn[s]),
			.ldoPullDn  (ldoPullDn[s]),
			.ldoHighV   (ldoHighV[s]),
			.cardSig    (cardSig[s*SIG_W +: SIG_W]),
			.cardDrvEn  (cardDrvEn[s]),
			.cardPullDn (cardPullDn[s])
		);
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// other status bits belong elsewhere, they read zero here
	always_comb begin
		statusByte = 8'h00;
		statusByte[`DSS_STATUS_LSB +: 2*`DSS_STATUS_W] = statusCodes;
		case (ptr_q)
			`DSS_OFS_STATUS:  readByte = statusByte;
			`DSS_OFS_CONTROL: readByte = ctrl_q;
			default:          readByte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// bus line events
	// ----------------------------------------------------------------
	// lines are synchronous, one stage of history is enough for edges
	assign sclRise   = sclIn & ~scl_q;
	assign sclFall   = ~sclIn & scl_q;
	assign startSeen = sclIn & scl_q & sda_q & ~sdaIn;
	assign stopSeen  = sclIn & scl_q & ~sda_q & sdaIn;
	assign rxNext    = {rxShift_q[6:0], sdaIn};

	// ----------------------------------------------------------------
	// serial slave sequencer and register writes
	// ----------------------------------------------------------------
	always_comb begin
		state_d     = state_q;
		ctrlWe      = 1'b0;
		ptr_d       = ptr_q;
		rxShift_d   = rxShift_q;
		txShift_d   = txShift_q;
		bitCnt_d    = bitCnt_q;
		readMode_d  = readMode_q;
		firstByte_d = firstByte_q;
		nack_d      = nack_q;
		sdaOe_d     = sdaOe_q;
		if (startSeen) begin
			// repeated start restarts addressing, pointer is kept
			state_d  = dss_pkg::DSS_I2C_ADDR;
			bitCnt_d = 4'h0;
			sdaOe_d  = 1'b0;
		end else if (stopSeen) begin
			state_d = dss_pkg::DSS_I2C_IDLE;
			sdaOe_d = 1'b0;
		end else begin
			case (state_q)
				dss_pkg::DSS_I2C_IDLE: begin
					sdaOe_d = 1'b0;
				end
				dss_pkg::DSS_I2C_ADDR: begin
					if (sclRise) begin
						rxShift_d = rxNext;
						bitCnt_d  = bitCnt_q + 4'h1;
					end else if (sclFall && bitCnt_q == `DSS_BYTE_BITS) begin
						if (rxShift_q[7:1] == DEV_ADDR) begin
							readMode_d  = rxShift_q[0];
							firstByte_d = ~rxShift_q[0];
							sdaOe_d     = 1'b1;
							state_d     = dss_pkg::DSS_I2C_AACK;
						end else begin
							state_d = dss_pkg::DSS_I2C_IDLE;
						end
					end
				end
				dss_pkg::DSS_I2C_AACK: begin
					if (sclFall) begin
						bitCnt_d = 4'h0;
						if (readMode_q) begin
							txShift_d = readByte;
							ptr_d     = ptr_q + 8'h01;
							sdaOe_d   = ~readByte[7];
							state_d   = dss_pkg::DSS_I2C_RDATA;
						end else begin
							sdaOe_d = 1'b0;
							state_d = dss_pkg::DSS_I2C_WDATA;
						end
					end
				end
				dss_pkg::DSS_I2C_WDATA: begin
					if (sclRise) begin
						rxShift_d = rxNext;
						bitCnt_d  = bitCnt_q + 4'h1;
					end else if (sclFall && bitCnt_q == `DSS_BYTE_BITS) begin
						if (firstByte_q) begin
							ptr_d       = rxShift_q;
							firstByte_d = 1'b0;
						end else begin
							// stored verbatim: state 10 is not blocked
							if (ptr_q == `DSS_OFS_CONTROL) begin
								ctrlWe = 1'b1;
							end
							ptr_d = ptr_q + 8'h01;
						end
						// status offset is read only, a write is acked and dropped
						sdaOe_d = 1'b1;
						state_d = dss_pkg::DSS_I2C_WACK;
					end
				end
				dss_pkg::DSS_I2C_WACK: begin
					if (sclFall) begin
						sdaOe_d  = 1'b0;
						bitCnt_d = 4'h0;
						state_d  = dss_pkg::DSS_I2C_WDATA;
					end
				end
				dss_pkg::DSS_I2C_RDATA: begin
					if (sclFall) begin
						if (bitCnt_q == `DSS_LAST_TX_BIT) begin
							sdaOe_d  = 1'b0;
							bitCnt_d = 4'h0;
							state_d  = dss_pkg::DSS_I2C_RACK;
						end else begin
							txShift_d = {txShift_q[6:0], 1'b0};
							sdaOe_d   = ~txShift_q[6];
							bitCnt_d  = bitCnt_q + 4'h1;
						end
					end
				end
				dss_pkg::DSS_I2C_RACK: begin
					if (sclRise) begin
						nack_d = sdaIn;
					end else if (sclFall) begin
						if (nack_q) begin
							state_d = dss_pkg::DSS_I2C_IDLE;
						end else begin
							txShift_d = readByte;
							ptr_d     = ptr_q + 8'h01;
							sdaOe_d   = ~readByte[7];
							state_d   = dss_pkg::DSS_I2C_RDATA;
						end
					end
				end
				default: begin
					state_d = dss_pkg::DSS_I2C_IDLE;
					sdaOe_d = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q     <= dss_pkg::DSS_I2C_IDLE;
			ptr_q       <= 8'h00;
			rxShift_q   <= 8'h00;
			txShift_q   <= 8'h00;
			bitCnt_q    <= 4'h0;
			readMode_q  <= 1'b0;
			firstByte_q <= 1'b0;
			nack_q      <= 1'b0;
			sdaOe_q     <= 1'b0;
			sdaOut_q    <= 1'b0;
		end else begin
			state_q     <= state_d;
			ptr_q       <= ptr_d;
			rxShift_q   <= rxShift_d;
			txShift_q   <= txShift_d;
			bitCnt_q    <= bitCnt_d;
			readMode_q  <= readMode_d;
			firstByte_q <= firstByte_d;
			nack_q      <= nack_d;
			sdaOe_q     <= sdaOe_d;
			sdaOut_q    <= 1'b0; // open drain: only ever pulls low
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// stored verbatim: no field is filtered or tied to another field
	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrlWe) begin
			ctrl_d = rxShift_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q <= `DSS_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------------------------------
	// bus line history
	// ----------------------------------------------------------------
	// reset to the idle level, so no false edge follows reset
	always_comb begin
		scl_d = sclIn;
		sda_d = sdaIn;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
		end
	end

	assign sdaOut = sdaOut_q;
	assign sdaOe  = sdaOe_q;

endmodule : dss_slot_ctrl_regs

`default_nettype wire

/* test/dss_host_model.sv */
`default_nettype none

module dss_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h3c
) (
	input  wire logic ref_clk,
	input  wire logic sdaOe,
	output var  logic sclQ,
	output wire logic sdaW
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// serial host, phases of four clocks
	// ----------------------------------------
	logic sdaLow = 1'b0;

	// pull-up on the wire, so a released line reads high
	assign sdaW = !(sdaLow || sdaOe);

	initial sclQ = 1'b1;

	task automatic w4();
		repeat (4) @(posedge ref_clk);
	endtask

	// sda moves only while scl is low
	task automatic bitx(input logic b, output logic r);
		sdaLow <= !b;
		w4();
		sclQ <= 1'b1;
		w4();
		r = sdaW;
		sclQ <= 1'b0;
		w4();
	endtask

	// also serves as repeated start, scl is low on entry then
	task automatic start();
		sdaLow <= 1'b0;
		w4();
		sclQ <= 1'b1;
		w4();
		sdaLow <= 1'b1;
		w4();
		sclQ <= 1'b0;
		w4();
	endtask

	task automatic stop();
		sdaLow <= 1'b1;
		w4();
		sclQ <= 1'b1;
		w4();
		sdaLow <= 1'b0;
		w4();
	endtask

	task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic nak);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(last, nak);
	endtask

	// pointer then one data byte, or a repeated start and one read ended by nack
	task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [7:0] d,
		output logic [7:0] q, output logic nak);
		logic [7:0] x;
		logic       n0, n1, n2;
		start();
		xbyte({DEV_ADDR, 1'b0}, 1'b1, x, n0);
		xbyte(ptr, 1'b1, x, n1);
		if (rd) begin
			start();
			xbyte({DEV_ADDR, 1'b1}, 1'b1, x, n2);
			xbyte(8'hff, 1'b1, q, x[0]);
		end else begin
			xbyte(d, 1'b1, x, n2);
			q = x;
		end
		stop();
		nak = n0 | n1 | n2;
	endtask

	// address byte alone, a foreign address must go unanswered
	task automatic probe(input logic [6:0] a, output logic nak);
		logic [7:0] x;
		start();
		xbyte({a, 1'b0}, 1'b1, x, nak);
		stop();
	endtask
endmodule // dss_host_model

`default_nettype wire

/* test/dss_slot_ctrl_regs_chk.sv */
`default_nettype none

module dss_slot_ctrl_regs_chk #(
	parameter logic [6:0] DEV_ADDR = 7'h3c,
	parameter int         SIG_W    = 3
) (
	input wire logic               ref_clk,
	input wire logic               srst,
	input wire logic               sclIn,
	input wire logic               sdaIn,
	input wire logic               sdaOut,
	input wire logic               sdaOe,
	input wire logic [2*SIG_W-1:0] bbSig,
	input wire logic [1:0]         ldoOn,
	input wire logic [1:0]         ldoPullDn,
	input wire logic [1:0]         ldoHighV,
	input wire logic [2*SIG_W-1:0] cardSig,
	input wire logic [1:0]         cardDrvEn,
	input wire logic [1:0]         cardPullDn
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// pin relations
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking

	property p_ldo_pd;
		disable iff (srst) ldoPullDn == ~ldoOn;
	endproperty
	a_ldo_pd: assert property (p_ldo_pd) else $error("ldo pull-down wrong");

	property p_drv_en;
		disable iff (srst) cardDrvEn == ldoOn;
	endproperty
	a_drv_en: assert property (p_drv_en) else $error("driver enable wrong");

	property p_card_pd;
		disable iff (srst) cardPullDn == ~cardDrvEn;
	endproperty
	a_card_pd: assert property (p_card_pd) else $error("card pull-down wrong");

	property p_sig0_off;
		disable iff (srst) !cardDrvEn[0] |-> cardSig[SIG_W-1:0] == '0;
	endproperty
	a_sig0_off: assert property (p_sig0_off) else $error("slot 0 not low");

	property p_sig1_off;
		disable iff (srst) !cardDrvEn[1] |-> cardSig[2*SIG_W-1:SIG_W] == '0;
	endproperty
	a_sig1_off: assert property (p_sig1_off) else $error("slot 1 not low");

	// reset is the antecedent here, so no disable
	property p_rst;
		srst |=> ldoOn == 2'b00 && cardPullDn == 2'b11 && ldoHighV == 2'b00 && !sdaOe;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");

	property p_sda_out;
		disable iff (srst) sdaOut == 1'b0;
	endproperty
	a_sda_out: assert property (p_sda_out) else $error("sda driven high");

	// updates land only after a write byte ends on a falling scl
	property p_ldo_scl;
		disable iff (srst) $changed(ldoOn) && !$past(srst) |-> !sclIn;
	endproperty
	a_ldo_scl: assert property (p_ldo_scl) else $error("ldo moved mid bit");

	c_on: cover property (disable iff (srst) ldoOn == 2'b11);
	c_hv: cover property (disable iff (srst) ldoHighV == 2'b11 && cardDrvEn == 2'b11);
	c_ack: cover property (disable iff (srst) $rose(sdaOe));
endmodule // dss_slot_ctrl_regs_chk

bind dss_slot_ctrl_regs dss_slot_ctrl_regs_chk #(.DEV_ADDR(DEV_ADDR), .SIG_W(SIG_W)) i_chk (
	.ref_clk(ref_clk), .srst(srst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .bbSig(bbSig), .ldoOn(ldoOn), .ldoPullDn(ldoPullDn),
	.ldoHighV(ldoHighV), .cardSig(cardSig), .cardDrvEn(cardDrvEn), .cardPullDn(cardPullDn)
);

`default_nettype wire

/* test/test_dss_slot_ctrl_regs.sv */
`include "dss_consts.svh"
`default_nettype none

module test_dss_slot_ctrl_regs;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// bench
	// ----------------------------------------
	localparam int SW = 3;
	logic              ref_clk = 1'b0;
	logic              srst    = 1'b1;
	logic [31:0]       rnd     = 32'h0;
	int                seed    = 32'hb2a4cdeb;
	int                badCount = 0;
	int                compares = 0;
	wire logic         scl, sda, sdaOut, sdaOe;
	wire logic [2*SW-1:0] bbSig, cardSig;
	wire logic [1:0]   ldoOn, ldoPullDn, ldoHighV, cardDrvEn, cardPullDn;

	assign bbSig = rnd[2*SW-1:0];

	dss_slot_ctrl_regs #(.SIG_W(SW)) i_dut (
		.ref_clk(ref_clk), .srst(srst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .bbSig(bbSig), .ldoOn(ldoOn), .ldoPullDn(ldoPullDn),
		.ldoHighV(ldoHighV), .cardSig(cardSig), .cardDrvEn(cardDrvEn),
		.cardPullDn(cardPullDn)
	);

	dss_host_model i_host (.ref_clk(ref_clk), .sdaOe(sdaOe), .sclQ(scl), .sdaW(sda));

	initial forever #2 ref_clk = ~ref_clk;

	// one draw per edge feeds the card inputs and the control values alike
	always @(posedge ref_clk) rnd <= $random(seed);

	function automatic logic [1:0] sts(input logic [7:0] c, input int s);
		logic [1:0] st;
		st = c[4*s+2 +: 2];
		if (!c[4*s]) return dss_pkg::DSS_STS_DOWN;
		if (st == dss_pkg::DSS_STATE_ISOLATED) return dss_pkg::DSS_STS_ISOLATED;
		if (st == dss_pkg::DSS_STATE_ACTIVE) return dss_pkg::DSS_STS_ACTIVE;
		return dss_pkg::DSS_STS_POWERED;
	endfunction

	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			badCount++;
			$display("[FAIL] %s exp %h seen %h", n, exp, seen);
		end
	endtask

	// write, read both registers back, then look at the pins
	task automatic trial(input logic [7:0] c);
		logic [7:0]      q, es;
		logic            nak;
		logic [2*SW-1:0] h, b;
		logic [1:0]      e;
		i_host.xfer(1'b0, `DSS_OFS_CONTROL, c, q, nak);
		chk("ack", {7'h00, nak}, 8'h00);
		i_host.xfer(1'b1, `DSS_OFS_CONTROL, 8'h00, q, nak);
		chk("ctrl", q, c);
		i_host.xfer(1'b1, `DSS_OFS_STATUS, 8'h00, q, nak);
		chk("status", q, {sts(c, 1), sts(c, 0), 4'h0});
		@(posedge ref_clk);
		#1 h = cardSig;
		@(posedge ref_clk);
		b = bbSig;
		#1;
		chk("ldo on", {6'h00, ldoOn}, {6'h00, c[4], c[0]});
		chk("ldo pd", {6'h00, ldoPullDn}, {6'h00, !c[4], !c[0]});
		chk("ldo v", {6'h00, ldoHighV}, {6'h00, c[5], c[1]});
		for (int s = 0; s < 2; s++) begin
			e = sts(c, s);
			es = {5'h00, e == 2'b11 ? b[s*SW +: SW] : e == 2'b01 ? h[s*SW +: SW] : 3'h0};
			chk("drv en", {7'h00, cardDrvEn[s]}, {7'h00, e != 2'b00});
			chk("card pd", {7'h00, cardPullDn[s]}, {7'h00, e == 2'b00});
			chk("card sig", {5'h00, cardSig[s*SW +: SW]}, es);
		end
	endtask

	task automatic wrap_up();
		if (badCount == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// main sequence: reset values, every state and regulator pair, odd accesses
	initial begin
		logic [7:0] c, q;
		logic       nak;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		i_host.xfer(1'b1, `DSS_OFS_CONTROL, 8'h00, q, nak);
		chk("ctrl rst", q, `DSS_CTRL_RESET);
		chk("pd rst", {6'h00, cardPullDn}, 8'h03);
		for (int i = 0; i < 24; i++) begin
			c = rnd[15:8];
			if (i < 16) begin
				c[3:2] = i[1:0];
				c[0] = i[2];
				c[7:6] = i[3:2];
				c[4] = i[1];
			end else begin
				if (c[3:2] == 2'b10) c[2] = 1'b1;
				if (c[7:6] == 2'b10) c[6] = 1'b1;
			end
			trial(c);
		end
		i_host.xfer(1'b0, `DSS_OFS_STATUS, 8'hff, q, nak);
		i_host.xfer(1'b1, `DSS_OFS_CONTROL, 8'h00, q, nak);
		chk("ro status", q, c);
		i_host.xfer(1'b1, 8'h0c, 8'h00, q, nak);
		chk("unmapped", q, 8'h00);
		i_host.probe(7'h3d, nak);
		chk("foreign addr", {7'h00, nak}, 8'h01);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		i_host.xfer(1'b1, `DSS_OFS_CONTROL, 8'h00, q, nak);
		chk("ctrl rst2", q, 8'h00);
		wrap_up();
	end

	// the run needs about 34k clocks
	initial begin
		#300000;
		badCount++;
		wrap_up();
	end
endmodule // test_dss_slot_ctrl_regs

`default_nettype wire
